//--- logic/sfn_consts.svh
// offsets, field positions, reset values and timing counts of the emission scheduler
`ifndef SFN_CONSTS_SVH
`define SFN_CONSTS_SVH
`define SFN_CLK_NS 50
`define SFN_TICK_NS 100
`define SFN_ONE_S_NS 1000000000
`define SFN_TICKS_PER_S (`SFN_ONE_S_NS / `SFN_TICK_NS)
`define SFN_TS_MAX 24'h98967F
`define SFN_TS_NONE 24'hFFFFFF
`define SFN_PKT_LAST 8'hBB
`define SFN_PID_HI_BYTE 8'h01
`define SFN_PID_LO_BYTE 8'h02
`define SFN_TS_BYTE 8'h04
`define SFN_DLY_BYTE 8'h07
`define SFN_FN_BYTE 8'h0A
`define SFN_FN_BIT_A 1
`define SFN_FN_BIT_B 0
`define SFN_REG_CTRL 5'h00
`define SFN_REG_PID 5'h04
`define SFN_REG_PROC 5'h08
`define SFN_REG_STATUS 5'h0C
`define SFN_REG_TARGET 5'h10
`define SFN_REG_TIME 5'h14
`define SFN_REG_HYB 5'h18
`define SFN_CTRL_EN 0
`define SFN_CTRL_FNCHK 1
`define SFN_ST_ARMED 0
`define SFN_ST_HOLD 1
`define SFN_ST_MARKER 2
`define SFN_ST_RANGE 3
`define SFN_ST_INTERVAL 4
`define SFN_ST_HYBRID 5
`define SFN_CTRL_RST 2'h0
`define SFN_PID_RST 13'h0000
`define SFN_PROC_RST 24'h000000
`define SFN_HYB_RST 24'h000000
`endif

//--- logic/sfn_pkg.sv
// types of the emission scheduler
package sfn_pkg;
   typedef enum logic [1:0] {
      ST_PASS = 2'b00,
      ST_ARMED = 2'b01,
      ST_HOLD = 2'b10
   } sched_e;
   typedef logic [23:0] ticks_t;
endpackage

//--- logic/sfn_link_if.sv
// carrier between the sync packet parser, the time base and the scheduler core
`timescale 1ns/1ns
interface sfn_link_if;
   logic [12:0] pid_sel;
   logic fields_valid;
   sfn_pkg::ticks_t time_stamp;
   sfn_pkg::ticks_t max_delay;
   logic [1:0] frame_num;
   sfn_pkg::ticks_t local_time;
   logic tick;
   modport parser (input pid_sel, output fields_valid, output time_stamp, output max_delay,
      output frame_num);
   modport timebase (output local_time, output tick);
   modport core (output pid_sel, input fields_valid, input time_stamp, input max_delay,
      input frame_num, input local_time, input tick);
endinterface

//--- logic/sfn_time_base.sv
// local 100 ns counter locked to the pulse per second and the 10 MHz reference
`timescale 1ns/1ns
`include "sfn_consts.svh"
module sfn_time_base #(
   parameter logic [24:0] TICKS_PER_S = 25'(`SFN_TICKS_PER_S)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // references
   input wire logic pps,
   input wire logic ref_10m,
   // to core
   sfn_link_if.timebase lnk
);
   logic pps_q;
   logic ref_q;
   logic tick_q;
   sfn_pkg::ticks_t cnt_q;
   logic pps_edge;
   logic ref_edge;
   localparam sfn_pkg::ticks_t LAST = 24'(TICKS_PER_S - 25'h0000001);

   assign pps_edge = pps & ~pps_q;
   assign ref_edge = ref_10m & ~ref_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pps_q <= 1'b0;
         ref_q <= 1'b0;
      end
      else
      begin
         pps_q <= pps;
         ref_q <= ref_10m;
      end
   end

   // pps restarts the second, each reference edge is one tick
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 24'h000000;
      else if (pps_edge)
         cnt_q <= 24'h000000;
      else if (ref_edge)
         cnt_q <= (cnt_q >= LAST) ? 24'h000000 : cnt_q + 24'h000001;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         tick_q <= 1'b0;
      else
         tick_q <= ref_edge | pps_edge;
   end

   assign lnk.local_time = cnt_q;
   assign lnk.tick = tick_q;
endmodule // sfn_time_base

//--- logic/sfn_sync_parser.sv
// picks the sync packet out of the transport stream and captures its time fields
`timescale 1ns/1ns
`include "sfn_consts.svh"
module sfn_sync_parser (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // accepted stream bytes
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_sop,
   // to core
   sfn_link_if.parser lnk
);
   logic [7:0] idx_q;
   logic [7:0] idx;
   logic [4:0] pid_hi_q;
   logic match_q;
   logic done_q;
   sfn_pkg::ticks_t ts_q;
   sfn_pkg::ticks_t dly_q;
   logic [1:0] fn_q;

   assign idx = byte_sop ? 8'h00 : idx_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         idx_q <= 8'h00;
      else if (byte_valid)
         idx_q <= idx + 8'h01;
   end

   // known identifier selects the sync packet
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pid_hi_q <= 5'h00;
         match_q <= 1'b0;
      end
      else if (byte_valid)
      begin
         if (byte_sop)
            match_q <= 1'b0;
         if (idx == `SFN_PID_HI_BYTE)
            pid_hi_q <= byte_data[4:0];
         if (idx == `SFN_PID_LO_BYTE)
            match_q <= ({pid_hi_q, byte_data} == lnk.pid_sel);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ts_q <= 24'h000000;
         dly_q <= 24'h000000;
         fn_q <= 2'h0;
      end
      else if (byte_valid && match_q)
      begin
         if (idx >= `SFN_TS_BYTE && idx < `SFN_TS_BYTE + 8'h03)
            ts_q <= {ts_q[15:0], byte_data};
         if (idx >= `SFN_DLY_BYTE && idx < `SFN_DLY_BYTE + 8'h03)
            dly_q <= {dly_q[15:0], byte_data};
         if (idx == `SFN_FN_BYTE)
            fn_q <= {byte_data[`SFN_FN_BIT_A], byte_data[`SFN_FN_BIT_B]};
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         done_q <= 1'b0;
      else
         done_q <= byte_valid && match_q && (idx == `SFN_PKT_LAST);
   end

   assign lnk.fields_valid = done_q;
   assign lnk.time_stamp = ts_q;
   assign lnk.max_delay = dly_q;
   assign lnk.frame_num = fn_q;
endmodule // sfn_sync_parser

//--- logic/sfn_frame_emission_scheduler.sv
// frame emission scheduler: holds the frame after each accepted sync stamp until the local time reaches its stamped instant
`timescale 1ns/1ns
`include "sfn_consts.svh"
//
// Contract
// - Emission time counts 100 ns ticks and never exceeds 0x98967F, one second.
// - With several frames per superframe, only the stamp of frame number 0 aligns.
// - No compensation is made for time interleaver latency; its shortest tap is zero.
// - A stamp other than 0xFFFFFF sets the superframe marker bit in that superframe.
// - The sync packet is found by identifier, its fields added, frame M+1 held until then.
// - The emission instant is advanced by the own processing delay, not interleaver delay.
// - Local time comes from the pulse per second and the 10 MHz reference.
// - Without SFN, the offset to the satellite frame stays within 5 % of a frame.
// - Frames repeat at less than one second.
module sfn_frame_emission_scheduler #(
   parameter logic [24:0] TICKS_PER_S = 25'(`SFN_TICKS_PER_S)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // timing references
   input wire logic pps,
   input wire logic ref_10m,
   input wire logic sat_frame_start,
   input wire logic superframe_start,
   // transport stream in
   input wire logic ts_valid,
   input wire logic [7:0] ts_data,
   input wire logic ts_sop,
   input wire logic ts_sof,
   output logic ts_ready,
   // stream to interleaver
   output logic il_valid,
   output logic [7:0] il_data,
   output logic il_sop,
   output logic il_sof,
   output logic emit_pulse,
   output logic superframe_marker_bit,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_i;
   sfn_link_if lnk();
   sfn_pkg::sched_e st_q;
   sfn_pkg::ticks_t emit_q;
   logic [1:0] ctrl_q;
   logic [12:0] pid_q;
   sfn_pkg::ticks_t proc_q;
   sfn_pkg::ticks_t hyb_q;
   logic marker_q;
   logic range_err_q;
   logic intv_err_q;
   logic hyb_err_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic il_valid_q;
   logic [7:0] il_data_q;
   logic il_sop_q;
   logic il_sof_q;
   logic emit_q_p;
   sfn_pkg::ticks_t intv_q;
   sfn_pkg::ticks_t since_q;
   sfn_pkg::ticks_t period_q;
   logic accept;
   logic due;
   logic release_now;
   logic stamp_ok;
   logic [24:0] sum;
   logic [24:0] wrapped;
   logic [24:0] advanced;
   logic wr;
   logic clr_range;
   logic clr_intv;
   logic clr_hyb;
   localparam sfn_pkg::ticks_t ONE_S = 24'(TICKS_PER_S);

   // reset release through two flops
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_i = rst_s2_q;

   sfn_time_base #(
      .TICKS_PER_S(TICKS_PER_S)
   ) u_time (
      .mclk(mclk),
      .rst_n(rst_i),
      .pps(pps),
      .ref_10m(ref_10m),
      .lnk(lnk.timebase)
   );

   sfn_sync_parser u_parse (
      .mclk(mclk),
      .rst_n(rst_i),
      .byte_valid(accept),
      .byte_data(ts_data),
      .byte_sop(ts_sop),
      .lnk(lnk.parser)
   );

   assign lnk.pid_sel = pid_q;

   // emission instant: stamp plus offset, wrapped at one second, less own delay
   assign sum = {1'b0, lnk.time_stamp} + {1'b0, lnk.max_delay};
   assign wrapped = (sum >= TICKS_PER_S) ? sum - TICKS_PER_S : sum;
   // interleaver latency is deliberately left out of the advance
   assign advanced = (wrapped >= {1'b0, proc_q}) ? wrapped - {1'b0, proc_q} :
      wrapped + TICKS_PER_S - {1'b0, proc_q};
   assign stamp_ok = (lnk.time_stamp <= `SFN_TS_MAX) && (lnk.max_delay <= `SFN_TS_MAX);

   assign due = lnk.tick && (lnk.local_time == emit_q);
   assign release_now = (st_q == sfn_pkg::ST_HOLD) && due;
   // next frame start stalls the source until its instant
   assign ts_ready = !((st_q == sfn_pkg::ST_ARMED) && ts_sof) &&
      !((st_q == sfn_pkg::ST_HOLD) && !due);
   assign accept = ts_valid && ts_ready;

   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         st_q <= sfn_pkg::ST_PASS;
         emit_q <= 24'h000000;
      end
      else if (!ctrl_q[`SFN_CTRL_EN])
         st_q <= sfn_pkg::ST_PASS;
      else
      begin
         unique case (st_q)
            sfn_pkg::ST_PASS,
            sfn_pkg::ST_ARMED:
            begin
               if (st_q == sfn_pkg::ST_ARMED && ts_valid && ts_sof)
                  st_q <= sfn_pkg::ST_HOLD;
               else if (lnk.fields_valid && lnk.time_stamp != `SFN_TS_NONE && stamp_ok &&
                  (!ctrl_q[`SFN_CTRL_FNCHK] || lnk.frame_num == 2'h0))
               begin
                  st_q <= sfn_pkg::ST_ARMED;
                  emit_q <= advanced[23:0];
               end
            end
            sfn_pkg::ST_HOLD:
            begin
               if (due)
                  st_q <= sfn_pkg::ST_PASS;
            end
            default:
               st_q <= sfn_pkg::ST_PASS;
         endcase
      end
   end

   // output register towards the interleaver
   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         il_valid_q <= 1'b0;
         il_data_q <= 8'h00;
         il_sop_q <= 1'b0;
         il_sof_q <= 1'b0;
         emit_q_p <= 1'b0;
      end
      else
      begin
         il_valid_q <= accept;
         il_data_q <= accept ? ts_data : il_data_q;
         il_sop_q <= accept && ts_sop;
         il_sof_q <= accept && ts_sof;
         emit_q_p <= release_now;
      end
   end

   // marker raised by any stamp other than 0xFFFFFF, even out of range, dropped at the next superframe
   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
         marker_q <= 1'b0;
      else if (lnk.fields_valid && lnk.time_stamp != `SFN_TS_NONE)
         marker_q <= 1'b1;
      else if (superframe_start)
         marker_q <= 1'b0;
   end

   // ticks between frame starts must stay under one second
   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
         intv_q <= 24'h000000;
      else if (accept && ts_sof)
         intv_q <= 24'h000000;
      else if (lnk.tick && intv_q < ONE_S)
         intv_q <= intv_q + 24'h000001;
   end

   // offset from own emission to satellite frame start
   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         since_q <= 24'h000000;
         period_q <= 24'h000000;
      end
      else if (release_now)
      begin
         since_q <= 24'h000000;
         period_q <= since_q;
      end
      else if (lnk.tick && since_q != 24'hFFFFFF)
         since_q <= since_q + 24'h000001;
   end

   // sticky errors, set wins over software clear
   assign wr = avs_write && ack_q;
   assign clr_range = wr && avs_address == `SFN_REG_STATUS && avs_writedata[`SFN_ST_RANGE];
   assign clr_intv = wr && avs_address == `SFN_REG_STATUS && avs_writedata[`SFN_ST_INTERVAL];
   assign clr_hyb = wr && avs_address == `SFN_REG_STATUS && avs_writedata[`SFN_ST_HYBRID];

   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         range_err_q <= 1'b0;
         intv_err_q <= 1'b0;
         hyb_err_q <= 1'b0;
      end
      else
      begin
         if (lnk.fields_valid && lnk.time_stamp != `SFN_TS_NONE && !stamp_ok)
            range_err_q <= 1'b1;
         else if (clr_range)
            range_err_q <= 1'b0;
         if (lnk.tick && intv_q == ONE_S - 24'h000001)
            intv_err_q <= 1'b1;
         else if (clr_intv)
            intv_err_q <= 1'b0;
         if (sat_frame_start && since_q > hyb_q &&
            {1'b0, since_q} + {1'b0, hyb_q} < {1'b0, period_q})
            hyb_err_q <= 1'b1;
         else if (clr_hyb)
            hyb_err_q <= 1'b0;
      end
   end

   // register writes
   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         ctrl_q <= `SFN_CTRL_RST;
         pid_q <= `SFN_PID_RST;
         proc_q <= `SFN_PROC_RST;
         hyb_q <= `SFN_HYB_RST;
      end
      else if (wr)
      begin
         unique case (avs_address)
            `SFN_REG_CTRL: ctrl_q <= avs_writedata[1:0];
            `SFN_REG_PID: pid_q <= avs_writedata[12:0];
            `SFN_REG_PROC: proc_q <= avs_writedata[23:0];
            `SFN_REG_HYB: hyb_q <= avs_writedata[23:0];
            default: ;
         endcase
      end
   end

   // one wait cycle per access, read data captured on the first cycle
   always_ff @(posedge mclk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         ack_q <= (avs_read || avs_write) && !ack_q;
         if (avs_read && !ack_q)
         begin
            unique case (avs_address)
               `SFN_REG_CTRL: rdata_q <= {30'h00000000, ctrl_q};
               `SFN_REG_PID: rdata_q <= {19'h00000, pid_q};
               `SFN_REG_PROC: rdata_q <= {8'h00, proc_q};
               `SFN_REG_STATUS: rdata_q <= {26'h0000000, hyb_err_q, intv_err_q, range_err_q,
                  marker_q, st_q == sfn_pkg::ST_HOLD, st_q == sfn_pkg::ST_ARMED};
               `SFN_REG_TARGET: rdata_q <= {8'h00, emit_q};
               `SFN_REG_TIME: rdata_q <= {8'h00, lnk.local_time};
               `SFN_REG_HYB: rdata_q <= {8'h00, hyb_q};
               default: rdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign avs_readdata = rdata_q;
   assign il_valid = il_valid_q;
   assign il_data = il_data_q;
   assign il_sop = il_sop_q;
   assign il_sof = il_sof_q;
   assign emit_pulse = emit_q_p;
   assign superframe_marker_bit = marker_q;
endmodule // sfn_frame_emission_scheduler

//--- testbench/sfn_sched_props.sv
// port checker of the frame emission scheduler
`timescale 1ns/1ns
module sfn_sched_props #(
   parameter logic [24:0] TICKS_PER_S = 25'h00003E8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // stream
   input wire logic ts_valid,
   input wire logic [7:0] ts_data,
   input wire logic ts_sop,
   input wire logic ts_sof,
   input wire logic ts_ready,
   input wire logic il_valid,
   input wire logic [7:0] il_data,
   input wire logic il_sop,
   input wire logic il_sof,
   input wire logic emit_pulse,
   input wire logic superframe_start,
   input wire logic superframe_marker_bit,
   // bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_rd_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait state wrong");
   a_wr_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("write wait state wrong");
   a_idle_nowait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("wait without request");
   a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved");
   a_byte_pass: assert property (ts_valid && ts_ready |=> il_valid && il_data == $past(ts_data))
      else $error("byte not passed");
   a_no_byte: assert property (!(ts_valid && ts_ready) |=> !il_valid)
      else $error("byte from nowhere");
   a_mark_copy: assert property (ts_valid && ts_ready |=> il_sof == $past(ts_sof) && il_sop == $past(ts_sop))
      else $error("start marks lost");
   a_stall_sof: assert property (ts_valid && !ts_ready |-> ts_sof)
      else $error("stall off frame start");
   a_emit_cause: assert property (emit_pulse |-> $past(ts_valid && ts_ready && ts_sof) ##1 !emit_pulse)
      else $error("emit without release");
   a_marker_clear: assert property ($fell(superframe_marker_bit) |-> $past(superframe_start))
      else $error("marker dropped early");
endmodule // sfn_sched_props
bind sfn_frame_emission_scheduler sfn_sched_props #(.TICKS_PER_S(TICKS_PER_S)) u_props (
   .mclk(mclk), .rst_n(rst_n), .ts_valid(ts_valid), .ts_data(ts_data), .ts_sop(ts_sop),
   .ts_sof(ts_sof), .ts_ready(ts_ready), .il_valid(il_valid), .il_data(il_data),
   .il_sop(il_sop), .il_sof(il_sof), .emit_pulse(emit_pulse),
   .superframe_start(superframe_start), .superframe_marker_bit(superframe_marker_bit),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest));

//--- testbench/sfn_gps_ref_model.sv
// gps reference model: pulse per second, 10 MHz reference and its own 100 ns count
`timescale 1ns/1ns
module sfn_gps_ref_model #(
   parameter int TICKS = 1000
) (
   // clock
   input wire logic mclk,
   // references
   output logic pps,
   output logic ref_10m,
   output logic [23:0] ref_time
);
   int cyc_q = 0;
   initial
   begin
      pps = 1'b0;
      ref_10m = 1'b0;
      ref_time = 24'h000000;
   end
   // reference rises every second clock, one pulse each TICKS ticks
   always @(posedge mclk)
   begin
      ref_10m <= !ref_10m;
      cyc_q <= (cyc_q == 2 * TICKS - 1) ? 0 : cyc_q + 1;
      pps <= (cyc_q < 2);
      if (cyc_q == 0)
         ref_time <= 24'h000000;
      else if (!ref_10m)
         ref_time <= ref_time + 24'h000001;
   end
endmodule // sfn_gps_ref_model

//--- testbench/sfn_frame_emission_scheduler_tb.sv
// self-checking bench of the frame emission scheduler
`timescale 1ns/1ns
module sfn_frame_emission_scheduler_tb;
   localparam int TICKS = 1000;
   localparam logic [23:0] S_TS = 24'h000384;
   localparam logic [23:0] S_DLY = 24'h0000FA;
   localparam int S_PROC = 5;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic pps;
   logic ref_10m;
   logic [23:0] ref_time;
   logic sat_frame_start = 1'b0;
   logic superframe_start = 1'b0;
   logic ts_valid = 1'b0;
   logic [7:0] ts_data = 8'h00;
   logic ts_sop = 1'b0;
   logic ts_sof = 1'b0;
   logic ts_ready;
   logic il_valid;
   logic [7:0] il_data;
   logic il_sop;
   logic il_sof;
   logic emit_pulse;
   logic marker;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] rdata;
   logic [23:0] emit_time;
   int error_cnt = 0;
   int checks = 0;
   int il_cnt = 0;
   int emits = 0;
   always #25 mclk = ~mclk;
   sfn_gps_ref_model #(.TICKS(TICKS)) u_ref (.mclk(mclk), .pps(pps), .ref_10m(ref_10m),
      .ref_time(ref_time));
   sfn_frame_emission_scheduler #(.TICKS_PER_S(25'h00003E8)) u_dut (.mclk(mclk),
      .rst_n(rst_n), .pps(pps), .ref_10m(ref_10m), .sat_frame_start(sat_frame_start),
      .superframe_start(superframe_start), .ts_valid(ts_valid), .ts_data(ts_data),
      .ts_sop(ts_sop), .ts_sof(ts_sof), .ts_ready(ts_ready), .il_valid(il_valid),
      .il_data(il_data), .il_sop(il_sop), .il_sof(il_sof), .emit_pulse(emit_pulse),
      .superframe_marker_bit(marker), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   // counts passed bytes and emissions where outputs are settled
   always @(negedge mclk)
   begin
      il_cnt <= il_cnt + int'(il_valid === 1'b1);
      if (emit_pulse === 1'b1)
      begin
         emits <= emits + 1;
         emit_time <= ref_time;
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge mclk);
      // waitrequest and read data as sampled by this rising edge
      for (n = 0; n < 50 && avs_waitrequest !== 1'b0; n++)
         @(posedge mclk);
      if (n == 50)
      begin
         error_cnt++;
         stop_test();
      end
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // one 188-byte sync packet, first byte optionally a frame start
   task automatic send_pkt(input logic [12:0] pid, input logic [23:0] stamp,
      input logic [23:0] dly, input logic [1:0] fnum, input logic sof);
      logic [7:0] b;
      int n;
      for (int i = 0; i < 188; i++)
      begin
         case (i)
            0: b = 8'h47;
            1: b = {3'h0, pid[12:8]};
            2: b = pid[7:0];
            4: b = stamp[23:16];
            5: b = stamp[15:8];
            6: b = stamp[7:0];
            7: b = dly[23:16];
            8: b = dly[15:8];
            9: b = dly[7:0];
            10: b = {6'h00, fnum};
            default: b = i[7:0];
         endcase
         @(posedge mclk);
         ts_valid <= 1'b1;
         ts_data <= b;
         ts_sop <= (i == 0);
         ts_sof <= sof && (i == 0);
         @(negedge mclk);
         for (n = 0; n < 5000 && ts_ready !== 1'b1; n++)
            @(negedge mclk);
         if (n == 5000)
         begin
            error_cnt++;
            stop_test();
         end
      end
      @(posedge mclk);
      ts_valid <= 1'b0;
      ts_sop <= 1'b0;
      ts_sof <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   task automatic t_regs();
      logic [4:0] adr [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h18, 5'h1C};
      bus(1'b1, 5'h1C, 32'hFFFFFFFF);
      foreach (adr[i])
      begin
         bus(1'b0, adr[i], 32'h00000000);
         check("reset value", rdata, 32'h00000000);
      end
   endtask
   task automatic t_none();
      bus(1'b1, 5'h00, 32'h00000001);
      bus(1'b1, 5'h04, 32'h00000100);
      bus(1'b1, 5'h08, S_PROC);
      bus(1'b0, 5'h04, 32'h00000000);
      check("pid", rdata, 32'h00000100);
      @(posedge mclk);
      superframe_start <= 1'b1;
      sat_frame_start <= 1'b1;
      @(posedge mclk);
      superframe_start <= 1'b0;
      sat_frame_start <= 1'b0;
      send_pkt(13'h0100, 24'hFFFFFF, 24'h000010, 2'h0, 1'b1);
      check("marker", marker, 1'b0);
      bus(1'b0, 5'h0C, 32'h00000000);
      check("status", rdata[2:0], 3'h0);
      check("emits", emits, 0);
   endtask
   task automatic t_range();
      send_pkt(13'h0100, 24'h989680, 24'h000010, 2'h0, 1'b0);
      bus(1'b0, 5'h0C, 32'h00000000);
      // any stamp other than the none code raises the marker, even out of range
      check("range", rdata[3:0], 4'hC);
      bus(1'b1, 5'h0C, 32'h00000008);
      bus(1'b0, 5'h0C, 32'h00000000);
      check("range clear", rdata[3], 1'b0);
   endtask
   // satellite frame start far from own emission, then with a wide limit
   task automatic t_hyb();
      for (int k = 0; k < 2; k++)
      begin
         @(posedge mclk);
         sat_frame_start <= 1'b1;
         @(posedge mclk);
         sat_frame_start <= 1'b0;
         bus(1'b0, 5'h0C, 32'h00000000);
         check("hybrid", rdata[5], k == 0);
         bus(1'b1, 5'h18, 32'h00FFFFFF);
         bus(1'b1, 5'h0C, 32'h00000020);
      end
   endtask
   // over one second without a frame start, then the next superframe
   task automatic t_intv();
      repeat (2100) @(posedge mclk);
      superframe_start <= 1'b1;
      @(posedge mclk);
      superframe_start <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         bus(1'b0, 5'h0C, 32'h00000000);
         check("interval", rdata[4], k == 0);
         bus(1'b1, 5'h0C, 32'h00000010);
      end
      check("marker cleared", marker, 1'b0);
   endtask
   task automatic t_arm();
      int n;
      int d;
      send_pkt(13'h0100, S_TS, S_DLY, 2'h0, 1'b0);
      check("marker", marker, 1'b1);
      bus(1'b0, 5'h0C, 32'h00000000);
      check("armed", rdata[1:0], 2'h1);
      bus(1'b0, 5'h10, 32'h00000000);
      check("target", rdata, (S_TS + S_DLY) % TICKS - S_PROC);
      n = il_cnt;
      send_pkt(13'h0055, 24'hFFFFFF, 24'h000000, 2'h0, 1'b1);
      d = (int'(emit_time) - ((S_TS + S_DLY) % TICKS - S_PROC) + TICKS + 2) % TICKS;
      check("emits", emits, 1);
      check("emit slot", d <= 4, 1'b1);
      check("bytes", il_cnt - n, 188);
      bus(1'b0, 5'h0C, 32'h00000000);
      check("released", rdata[1:0], 2'h0);
   endtask
   task automatic t_fnum();
      bus(1'b1, 5'h00, 32'h00000003);
      for (int f = 3; f >= 0; f--)
      begin
         send_pkt(13'h0100, 24'h000064, 24'h00000A, f[1:0], 1'b0);
         bus(1'b0, 5'h0C, 32'h00000000);
         check("armed", rdata[0], f == 0);
      end
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (5) @(posedge mclk);
      t_regs();
      t_none();
      t_range();
      t_arm();
      t_hyb();
      t_fnum();
      t_intv();
      stop_test();
   end
endmodule // sfn_frame_emission_scheduler_tb
